/* design/sfls_pkg.sv */
// Constants shared by the startup fault LED signaller
package sfls_pkg;
   // Timing: clock in Hz, intervals in milliseconds and in clock cycles, code width in bits
   localparam int unsigned CLK_HZ          = 125_000_000;
   localparam int unsigned LIT_TIME_MS     = 900;
   localparam int unsigned DARK_TIME_MS    = 100;
   localparam int unsigned GAP_TIME_MS     = 1000;
   localparam int unsigned CYC_PER_MS      = CLK_HZ / 1000;
   localparam int unsigned LIT_CYCLES      = LIT_TIME_MS * CYC_PER_MS;
   localparam int unsigned DARK_CYCLES     = DARK_TIME_MS * CYC_PER_MS;
   localparam int unsigned GAP_CYCLES      = GAP_TIME_MS * CYC_PER_MS;
   localparam int unsigned CODE_BITS       = 8;

   // Presence byte
   localparam logic [7:0] PRESENCE_BOOT_VALUE = 8'h41;

   // Fault codes
   localparam logic [7:0] BIT_TEST_FAIL_BYTE   = 8'h01;
   localparam logic [7:0] BIT_TEST_FAIL_HALF   = 8'h02;
   localparam logic [7:0] BIT_TEST_FAIL_WORD   = 8'h03;
   localparam logic [7:0] ADDR_TEST_FAIL_BYTE  = 8'h04;
   localparam logic [7:0] ADDR_TEST_FAIL_HALF  = 8'h05;
   localparam logic [7:0] ADDR_TEST_FAIL_WORD  = 8'h06;
   localparam logic [7:0] SCAN_DOWNLOAD_FAIL   = 8'h10;
   localparam logic [7:0] SCAN_UNKNOWN_ERROR   = 8'h11;
   localparam logic [7:0] SCAN_OUTPUT_MISMATCH = 8'h12;
   localparam logic [7:0] SCAN_RETRY_EXHAUSTED = 8'h13;
   localparam logic [7:0] SCAN_BAD_COMMAND     = 8'h14;
   localparam logic [7:0] SCAN_BAD_STATE_MOVE  = 8'h15;
   localparam logic [7:0] SCAN_SHIFT_OVERFLOW  = 8'h16;

   // Fault causes, one per documented code
   typedef enum logic [3:0] {
      SFLS_BIT8, SFLS_BIT16, SFLS_BIT32, SFLS_ADDR8, SFLS_ADDR16, SFLS_ADDR32,
      SFLS_SCAN_DL, SFLS_SCAN_UNK, SFLS_SCAN_MIS, SFLS_SCAN_RETRY, SFLS_SCAN_CMD,
      SFLS_SCAN_STATE, SFLS_SCAN_OVF
   } sfls_cause_e;
endpackage

/* design/sfls_top.sv */
// Startup fault LED signaller: flash code serialiser, presence byte, watchdog flag
`timescale 1ns/10ps
`default_nettype none

module sfls_top #(
   parameter int unsigned LIT_CYC  = sfls_pkg::LIT_CYCLES,
   parameter int unsigned DARK_CYC = sfls_pkg::DARK_CYCLES,
   parameter int unsigned GAP_CYC  = sfls_pkg::GAP_CYCLES
) (
   // Clock and reset
   input  wire logic       ref_clk_in,
   input  wire logic       resetn_in,
   // Self-test results
   input  wire logic       fault_valid_in,
   input  wire logic [3:0] fault_cause_in,
   input  wire logic       boot_ok_in,
   // Firmware presence byte override
   input  wire logic       presence_wr_in,
   input  wire logic [7:0] presence_data_in,
   // Run state
   input  wire logic       card_stopped_in,
   input  wire logic       fw_error_in,
   input  wire logic       watchdog_expired_in,
   input  wire logic       watchdog_clear_in,
   // Outputs
   output logic            led_green_out,
   output logic            led_red_out,
   output logic [7:0]      presence_byte_out,
   output logic            watchdog_expired_flag_out,
   output logic            flashing_out
);

   ////////////////////////////////////////////////////////////////////////////
   // Reset synchroniser

   logic rst_meta_q;
   logic rst_n_q;

   always_ff @(posedge ref_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         rst_meta_q <= 1'b0;
         rst_n_q    <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rst_n_q    <= rst_meta_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Cause to code mapping

   function automatic logic [7:0] cause_to_code(input logic [3:0] cause);
      logic [7:0] code;
      code = 8'h00;
      case (cause)
         4'(sfls_pkg::SFLS_BIT8):       code = sfls_pkg::BIT_TEST_FAIL_BYTE;
         4'(sfls_pkg::SFLS_BIT16):      code = sfls_pkg::BIT_TEST_FAIL_HALF;
         4'(sfls_pkg::SFLS_BIT32):      code = sfls_pkg::BIT_TEST_FAIL_WORD;
         4'(sfls_pkg::SFLS_ADDR8):      code = sfls_pkg::ADDR_TEST_FAIL_BYTE;
         4'(sfls_pkg::SFLS_ADDR16):     code = sfls_pkg::ADDR_TEST_FAIL_HALF;
         4'(sfls_pkg::SFLS_ADDR32):     code = sfls_pkg::ADDR_TEST_FAIL_WORD;
         4'(sfls_pkg::SFLS_SCAN_DL):    code = sfls_pkg::SCAN_DOWNLOAD_FAIL;
         4'(sfls_pkg::SFLS_SCAN_UNK):   code = sfls_pkg::SCAN_UNKNOWN_ERROR;
         4'(sfls_pkg::SFLS_SCAN_MIS):   code = sfls_pkg::SCAN_OUTPUT_MISMATCH;
         4'(sfls_pkg::SFLS_SCAN_RETRY): code = sfls_pkg::SCAN_RETRY_EXHAUSTED;
         4'(sfls_pkg::SFLS_SCAN_CMD):   code = sfls_pkg::SCAN_BAD_COMMAND;
         4'(sfls_pkg::SFLS_SCAN_STATE): code = sfls_pkg::SCAN_BAD_STATE_MOVE;
         4'(sfls_pkg::SFLS_SCAN_OVF):   code = sfls_pkg::SCAN_SHIFT_OVERFLOW;
         default:                       code = 8'h00;
      endcase
      return code;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Fault capture: first fatal fault wins, held until reset

   logic [7:0] code_q;
   logic       armed_q;
   logic [7:0] new_code;

   // Unknown causes give zero and are dropped, so reserved codes never appear
   assign new_code = cause_to_code(fault_cause_in);

   always_ff @(posedge ref_clk_in or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         code_q  <= 8'h00;
         armed_q <= 1'b0;
      end
      else if (!armed_q && fault_valid_in && new_code != 8'h00)
      begin
         code_q  <= new_code;
         armed_q <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Flash sequencer

   typedef enum logic [1:0] {SFLS_IDLE, SFLS_LIT, SFLS_DARK, SFLS_GAP} sfls_state_e;

   sfls_state_e state_q;
   logic [31:0] tmr_q;
   logic [2:0]  bit_q;
   logic        tmr_done;

   assign tmr_done = (tmr_q == 32'h0000_0000);

   always_ff @(posedge ref_clk_in or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         state_q <= SFLS_IDLE;
         tmr_q   <= 32'h0000_0000;
         bit_q   <= 3'h7;
      end
      else
      begin
         case (state_q)
            SFLS_IDLE:
            begin
               if (armed_q)
               begin
                  state_q <= SFLS_LIT;
                  bit_q   <= 3'h7;
                  tmr_q   <= LIT_CYC - 1;
               end
            end
            SFLS_LIT:
            begin
               if (tmr_done)
               begin
                  state_q <= SFLS_DARK;
                  tmr_q   <= DARK_CYC - 1;
               end
               else
                  tmr_q <= tmr_q - 32'h1;
            end
            SFLS_DARK:
            begin
               if (!tmr_done)
                  tmr_q <= tmr_q - 32'h1;
               else if (bit_q == 3'h0)
               begin
                  state_q <= SFLS_GAP;
                  tmr_q   <= GAP_CYC - 1;
               end
               else
               begin
                  state_q <= SFLS_LIT;
                  bit_q   <= bit_q - 3'h1;
                  tmr_q   <= LIT_CYC - 1;
               end
            end
            SFLS_GAP:
            begin
               if (!tmr_done)
                  tmr_q <= tmr_q - 32'h1;
               else
               begin
                  // Loops until reset; there is no exit by design
                  state_q <= SFLS_LIT;
                  bit_q   <= 3'h7;
                  tmr_q   <= LIT_CYC - 1;
               end
            end
            default:
               state_q <= SFLS_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // LED drive: flash codes override run state display

   always_ff @(posedge ref_clk_in or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         led_green_out <= 1'b0;
         led_red_out   <= 1'b0;
         flashing_out  <= 1'b0;
      end
      else
      begin
         flashing_out <= armed_q;
         if (state_q == SFLS_LIT)
         begin
            led_green_out <= code_q[bit_q];
            led_red_out   <= !code_q[bit_q];
         end
         else if (armed_q)
         begin
            led_green_out <= 1'b0;
            led_red_out   <= 1'b0;
         end
         else
         begin
            // Red while stopped or faulted, green when running cleanly
            led_red_out   <= card_stopped_in || fw_error_in || watchdog_expired_flag_out;
            led_green_out <= !(card_stopped_in || fw_error_in || watchdog_expired_flag_out);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Presence byte and watchdog flag

   always_ff @(posedge ref_clk_in or negedge rst_n_q)
   begin
      if (!rst_n_q)
         presence_byte_out <= 8'h00;
      else if (presence_wr_in)
         presence_byte_out <= presence_data_in;
      else if (boot_ok_in && presence_byte_out == 8'h00)
         presence_byte_out <= sfls_pkg::PRESENCE_BOOT_VALUE;
   end

   // Set wins over clear so a timeout in the clearing cycle is kept
   always_ff @(posedge ref_clk_in or negedge rst_n_q)
   begin
      if (!rst_n_q)
         watchdog_expired_flag_out <= 1'b0;
      else if (watchdog_expired_in)
         watchdog_expired_flag_out <= 1'b1;
      else if (watchdog_clear_in)
         watchdog_expired_flag_out <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions

   a_lit_color: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
      state_q == SFLS_LIT |=> (led_green_out == code_q[$past(bit_q)]) && (led_red_out != led_green_out))
      else $error("LED colour does not match code bit");
   a_dark_off: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
      (state_q == SFLS_DARK || state_q == SFLS_GAP) |=> !led_green_out && !led_red_out)
      else $error("LED lit during off interval");
   a_lit_len: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
      $rose(state_q == SFLS_LIT) |-> (tmr_q == LIT_CYC - 1))
      else $error("Lit interval length wrong");
   a_dark_len: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
      $rose(state_q == SFLS_DARK) |-> (tmr_q == DARK_CYC - 1))
      else $error("Dark interval length wrong");
   a_gap_after: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
      $rose(state_q == SFLS_GAP) |-> bit_q == 3'h0 && tmr_q == GAP_CYC - 1)
      else $error("Gap not after last bit");
   a_msb_first: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
      $past(state_q) != SFLS_DARK && $rose(state_q == SFLS_LIT) |-> bit_q == 3'h7)
      else $error("Sequence does not start at msb");
   a_bit_step: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
      $past(state_q) == SFLS_DARK && state_q == SFLS_LIT |-> bit_q == $past(bit_q) - 3'h1)
      else $error("Bit order broken");
   a_code_legal: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
      armed_q |-> (code_q inside {[8'h01:8'h06], [8'h10:8'h16]}))
      else $error("Reserved fault code emitted");
   a_presence_def: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
      boot_ok_in && !presence_wr_in && presence_byte_out == 8'h00 |=> presence_byte_out == sfls_pkg::PRESENCE_BOOT_VALUE)
      else $error("Presence byte not set after boot");
   a_wdog_set: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
      watchdog_expired_in |=> watchdog_expired_flag_out)
      else $error("Watchdog flag not set");
   a_code_held: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
      armed_q |=> armed_q && $stable(code_q))
      else $error("Fault code changed while flashing");
   a_presence_wr: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
      presence_wr_in |=> presence_byte_out == $past(presence_data_in))
      else $error("Presence byte write lost");
   a_flash_flag: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
      armed_q |=> flashing_out)
      else $error("Flashing flag not raised");

   c_flash_one: cover property (@(posedge ref_clk_in) disable iff (!rst_n_q)
      state_q == SFLS_LIT && code_q[bit_q]);
   c_gap_wrap: cover property (@(posedge ref_clk_in) disable iff (!rst_n_q)
      state_q == SFLS_GAP ##1 state_q == SFLS_LIT);
   c_wdog: cover property (@(posedge ref_clk_in) disable iff (!rst_n_q)
      watchdog_expired_in && watchdog_clear_in);
   c_fw_presence: cover property (@(posedge ref_clk_in) disable iff (!rst_n_q)
      presence_wr_in && presence_data_in != 8'h41);

endmodule

`default_nettype wire

/* dv/sfls_led_model.sv */
// Partner model: LED observer that decodes the repeating flash code and checks its timing
`timescale 1ns/10ps
`default_nettype none
module sfls_led_model #(
   parameter int unsigned LIT_CYC  = 9,
   parameter int unsigned DARK_CYC = 3,
   parameter int unsigned GAP_CYC  = 7
) (
   // Clock and reset
   input  wire logic       clk_in,
   input  wire logic       resetn_in,
   // LED and state from the card
   input  wire logic       green_in,
   input  wire logic       red_in,
   input  wire logic       flashing_in,
   // Decoded code
   output logic            code_valid_out,
   output logic [7:0]      code_out,
   output logic            timing_ok_out
);
   logic        lit_q;
   logic        grn_q;
   logic        sync_q;
   logic        bad_q;
   logic [3:0]  nbits_q;
   logic [7:0]  shift_q;
   int unsigned cnt_q;
   wire logic   lit = green_in | red_in;

   assign code_out = shift_q;

   ////////////////////////////////////////////////////////////////////////////////
   // The first partial code is ignored: decoding starts only after a full gap
   always_ff @(posedge clk_in)
   begin
      code_valid_out <= 1'b0;
      if (!resetn_in || !flashing_in)
      begin
         sync_q        <= 1'b0;
         bad_q         <= 1'b0;
         lit_q         <= 1'b0;
         cnt_q         <= 0;
         timing_ok_out <= 1'b0;
      end
      else
      begin
         lit_q <= lit;
         grn_q <= green_in;
         cnt_q <= (lit == lit_q) ? cnt_q + 1 : 1;
         if (green_in && red_in)
            bad_q <= 1'b1;
         if (lit && !lit_q)
         begin
            if (cnt_q == DARK_CYC + GAP_CYC)
            begin
               code_valid_out <= sync_q;
               timing_ok_out  <= !bad_q && nbits_q == 4'h8;
               sync_q         <= 1'b1;
               bad_q          <= 1'b0;
               nbits_q        <= 4'h0;
            end
            else if (sync_q && (cnt_q != DARK_CYC || nbits_q == 4'h8))
               bad_q <= 1'b1;
         end
         if (!lit && lit_q && sync_q)
         begin
            shift_q <= {shift_q[6:0], grn_q};
            nbits_q <= nbits_q + 4'h1;
            if (cnt_q != LIT_CYC)
               bad_q <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

/* dv/startup_fault_led_signaller_bench.sv */
// Self-checking bench for the startup fault LED signaller
`timescale 1ns/10ps
`default_nettype none
module startup_fault_led_signaller_bench;
   localparam int unsigned LIT  = 9;
   localparam int unsigned DARK = 3;
   localparam int unsigned GAP  = 7;
   // Scaled host wait after reset before the presence check
   localparam int unsigned HOST_WAIT = 40;

   logic       ref_clk_in = 1'b0;
   logic       resetn_in = 1'b0;
   logic       fault_valid_in = 1'b0;
   logic [3:0] fault_cause_in = 4'h0;
   logic       boot_ok_in = 1'b0;
   logic       presence_wr_in = 1'b0;
   logic [7:0] presence_data_in = 8'h00;
   logic       card_stopped_in = 1'b0;
   logic       fw_error_in = 1'b0;
   logic       watchdog_expired_in = 1'b0;
   logic       watchdog_clear_in = 1'b0;
   logic       led_g;
   logic       led_r;
   logic [7:0] presence;
   logic       wd_flag;
   logic       flashing;
   logic       code_valid;
   logic [7:0] code;
   logic       timing_ok;
   logic [7:0] exp_q[$];
   int         n_fail = 0;
   int         checks_done = 0;
   int         cycles = 0;

   always #4 ref_clk_in = ~ref_clk_in;

   sfls_top #(.LIT_CYC(LIT), .DARK_CYC(DARK), .GAP_CYC(GAP)) dut (
      .ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .fault_valid_in(fault_valid_in),
      .fault_cause_in(fault_cause_in), .boot_ok_in(boot_ok_in), .presence_wr_in(presence_wr_in),
      .presence_data_in(presence_data_in), .card_stopped_in(card_stopped_in), .fw_error_in(fw_error_in),
      .watchdog_expired_in(watchdog_expired_in), .watchdog_clear_in(watchdog_clear_in),
      .led_green_out(led_g), .led_red_out(led_r), .presence_byte_out(presence),
      .watchdog_expired_flag_out(wd_flag), .flashing_out(flashing));

   sfls_led_model #(.LIT_CYC(LIT), .DARK_CYC(DARK), .GAP_CYC(GAP)) led_model (
      .clk_in(ref_clk_in), .resetn_in(resetn_in), .green_in(led_g), .red_in(led_r),
      .flashing_in(flashing), .code_valid_out(code_valid), .code_out(code), .timing_ok_out(timing_ok));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp)
      begin
         n_fail++;
         $display("Error at %0t: expected %h, got %h", $time, exp, got);
      end
   endtask

   task automatic test_done;
      $display("Comparisons %0d, mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic reset_card(input int unsigned n);
      @(negedge ref_clk_in);
      resetn_in = 1'b0;
      repeat (n) @(negedge ref_clk_in);
      chk(8'h00, {flashing, wd_flag, led_g, led_r, 4'h0});
      resetn_in = 1'b1;
      repeat (4) @(negedge ref_clk_in);
   endtask

   task automatic pulse(ref logic s);
      s = 1'b1;
      @(negedge ref_clk_in);
      s = 1'b0;
      repeat (3) @(negedge ref_clk_in);
   endtask

   task automatic led_chk(input logic [2:0] exp);
      repeat (3) @(negedge ref_clk_in);
      chk({5'h0, exp}, {5'h0, wd_flag, led_g, led_r});
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Watcher: each decoded code retires the oldest expectation
   always @(negedge ref_clk_in)
   begin
      if (code_valid === 1'b1)
      begin
         chk(exp_q.size() != 0 ? exp_q.pop_front() : 8'hxx, code);
         chk(8'h01, {7'h0, timing_ok});
      end
   end

   always @(posedge ref_clk_in)
   begin
      cycles++;
      if (cycles == 30000)
      begin
         n_fail++;
         $display("Error at %0t: expected %h, got %h", $time, 8'h00, 8'hff);
         test_done();
      end
   end

   initial
   begin
      logic [7:0] d;
      logic [7:0] e;
      void'($urandom(32'hcba1));
      reset_card(20);
      // Host side: wait before the first presence check
      boot_ok_in = 1'b1;
      repeat (HOST_WAIT) @(negedge ref_clk_in);
      chk(8'h41, presence);
      d = 8'($urandom);
      presence_data_in = d;
      pulse(presence_wr_in);
      chk((d == 8'h00) ? 8'h41 : d, presence);
      presence_data_in = 8'h00;
      pulse(presence_wr_in);
      chk(8'h41, presence);
      $display("Test presence done");
      led_chk(3'b010);
      card_stopped_in = 1'b1;
      led_chk(3'b001);
      card_stopped_in = 1'b0;
      fw_error_in = 1'b1;
      led_chk(3'b001);
      fw_error_in = 1'b0;
      pulse(watchdog_expired_in);
      led_chk(3'b101);
      pulse(watchdog_clear_in);
      led_chk(3'b010);
      // A timeout in the clearing cycle must keep the flag set
      watchdog_expired_in = 1'b1;
      watchdog_clear_in = 1'b1;
      @(negedge ref_clk_in);
      watchdog_expired_in = 1'b0;
      watchdog_clear_in = 1'b0;
      led_chk(3'b101);
      pulse(watchdog_clear_in);
      led_chk(3'b010);
      $display("Test status done");
      for (int c = 0; c < 16; c++)
      begin
         reset_card(4);
         fault_cause_in = 4'(c);
         pulse(fault_valid_in);
         if (c > 12)
            chk(8'h00, {7'h0, flashing});
         else
         begin
            e = (c < 6) ? 8'(c + 1) : 8'(c + 10);
            exp_q.push_back(e);
            exp_q.push_back(e);
            // A later fault must not replace the latched one
            fault_cause_in = 4'($urandom_range(12, 0));
            pulse(fault_valid_in);
            while (exp_q.size() != 0)
               @(negedge ref_clk_in);
         end
      end
      $display("Test flash codes done");
      test_done();
   end
endmodule
`default_nettype wire
